// File: core/far_ctrl.sv
// fan acoustic ramp control with apb register access
// Notes on behaviour
// - with smoothing on, duty moves toward a new value at the set rate
// - slow select clear: codes give full-scale ramps 37.5 s down to 0.8 s
// - slow select set: steps 1,2,3,4,8,12,24,48; ramps 52.2 s to 1.1 s
// - bit 3 set enables smoothing of remote 1 driven duty changes
// - bit 4 set syncs speed senses 2, 3 and 4 to fan drive 3
// - bit 4 clear syncs only speed senses 3 and 4 to fan drive 3
// - auto mode below threshold: drive 1 off if bit 5 clear, else minimum
// - auto mode below threshold: drive 2 off if bit 6 clear, else minimum
// - auto mode below threshold: drive 3 off if bit 7 clear, else minimum
// - register resets to zero and sits at its fixed map offset
// - after the lock bit is set, writes to the register are ignored
// - remote 1 channel bit in configuration six slows ramps four times
`timescale 1ns/1ns
`include "far_regs.svh"

module far_ctrl #(
    parameter far_pkg::far_slot_t SLOT_NORMAL_CYC =
        far_pkg::far_slot_t'(`FAR_SLOT_NORMAL_CYC),
    parameter far_pkg::far_slot_t SLOT_SLOW_CYC =
        far_pkg::far_slot_t'(`FAR_SLOT_SLOW_CYC)
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    input wire logic [7:0] I_TARGET_DUTY_1,
    input wire logic [7:0] I_TARGET_DUTY_2,
    input wire logic [7:0] I_TARGET_DUTY_3,
    input wire logic [7:0] I_MIN_DUTY_1,
    input wire logic [7:0] I_MIN_DUTY_2,
    input wire logic [7:0] I_MIN_DUTY_3,
    input wire logic [2:0] I_BELOW_LOW,
    output logic O_FAN_DRIVE_1,
    output logic O_FAN_DRIVE_2,
    output logic O_FAN_DRIVE_3,
    output logic [7:0] O_DUTY_1,
    output logic [7:0] O_DUTY_2,
    output logic [7:0] O_DUTY_3,
    output logic O_SPEED_SENSE_2_SYNC,
    output logic O_SPEED_SENSE_3_SYNC,
    output logic O_SPEED_SENSE_4_SYNC
);

    // reset release through two flops
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    function automatic far_pkg::far_duty_t step_of(input logic [2:0] code);
        far_pkg::far_duty_t s;
        s = `FAR_STEP_0;
        case (code)
            3'h0: s = `FAR_STEP_0;
            3'h1: s = `FAR_STEP_1;
            3'h2: s = `FAR_STEP_2;
            3'h3: s = `FAR_STEP_3;
            3'h4: s = `FAR_STEP_4;
            3'h5: s = `FAR_STEP_5;
            3'h6: s = `FAR_STEP_6;
            default: s = `FAR_STEP_7;
        endcase
        return s;
    endfunction

    // move cur toward tgt by at most step, never past it
    function automatic far_pkg::far_duty_t ramp_toward(
        input far_pkg::far_duty_t cur,
        input far_pkg::far_duty_t tgt,
        input far_pkg::far_duty_t step
    );
        far_pkg::far_duty_t r;
        r = tgt;
        if (tgt > cur) begin
            if (8'(tgt - cur) > step) begin
                r = 8'(cur + step);
            end
        end else if (cur > tgt) begin
            if (8'(cur - tgt) > step) begin
                r = 8'(cur - step);
            end
        end
        return r;
    endfunction

    // register file and apb slave
    logic [7:0] ramp_rate_code_r;
    logic [7:0] ramp_rate_code_nxt;
    logic [7:0] cfg6_r;
    logic [7:0] cfg6_nxt;
    logic lock_r;
    logic lock_nxt;
    logic [7:0] dctl_r;
    logic [7:0] dctl_nxt;
    far_pkg::far_apb_e apb_r;
    far_pkg::far_apb_e apb_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    far_pkg::far_duty_t duty_r [3];
    logic [9:0] idx;
    logic aligned;
    logic done;
    logic wr;
    logic [31:0] rd_val;
    logic rd_hit;

    assign idx = I_PADDR[11:2];
    assign aligned = (I_PADDR[1:0] == 2'h0);
    assign done = I_PSEL && I_PENABLE && pready_r;
    assign wr = done && I_PWRITE;

    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        if (!aligned) begin
            rd_hit = 1'b0;
        end else if (idx == `FAR_IDX_ACOUSTIC1) begin
            rd_val = {24'h0, ramp_rate_code_r};
        end else if (idx == `FAR_IDX_CFG6) begin
            rd_val = {24'h0, cfg6_r};
        end else if (idx == `FAR_IDX_CFG1) begin
            rd_val[`FAR_CFG1_LOCK_BIT] = lock_r;
        end else if (idx == `FAR_IDX_DRIVE_CTRL) begin
            rd_val = {24'h0, dctl_r};
        end else if (idx == `FAR_IDX_DUTY_STAT) begin
            rd_val = {8'h0, duty_r[2], duty_r[1], duty_r[0]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        apb_nxt = apb_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        ramp_rate_code_nxt = ramp_rate_code_r;
        cfg6_nxt = cfg6_r;
        lock_nxt = lock_r;
        dctl_nxt = dctl_r;
        case (apb_r)
            far_pkg::FAR_APB_IDLE: begin
                // answer one cycle into the access phase
                if (I_PSEL && I_PENABLE) begin
                    apb_nxt = far_pkg::FAR_APB_ANSWER;
                    pready_nxt = 1'b1;
                    pslverr_nxt = !rd_hit;
                    prdata_nxt = I_PWRITE ? 32'h0 : rd_val;
                end
            end
            default: begin
                apb_nxt = far_pkg::FAR_APB_IDLE;
            end
        endcase
        if (wr && rd_hit) begin
            if (idx == `FAR_IDX_ACOUSTIC1) begin
                if (!lock_r) begin
                    ramp_rate_code_nxt = I_PWDATA[7:0];
                end
            end else if (idx == `FAR_IDX_CFG6) begin
                cfg6_nxt = I_PWDATA[7:0];
            end else if (idx == `FAR_IDX_CFG1) begin
                // lock only clears on reset
                lock_nxt = lock_r | I_PWDATA[`FAR_CFG1_LOCK_BIT];
            end else if (idx == `FAR_IDX_DRIVE_CTRL) begin
                dctl_nxt = {2'h0, I_PWDATA[5:0]};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ramp_rate_code_r <= `FAR_ACOUSTIC1_RST;
            cfg6_r <= `FAR_CFG6_RST;
            lock_r <= 1'b0;
            dctl_r <= `FAR_DCTL_RST;
            apb_r <= far_pkg::FAR_APB_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            ramp_rate_code_r <= ramp_rate_code_nxt;
            cfg6_r <= cfg6_nxt;
            lock_r <= lock_nxt;
            dctl_r <= dctl_nxt;
            apb_r <= apb_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ramp time slot
    far_pkg::far_slot_t slot_cnt_r;
    far_pkg::far_slot_t slot_cnt_nxt;
    far_pkg::far_slot_t slot_len;
    logic slot_tick;

    always_comb begin
        slot_len = cfg6_r[`FAR_CFG6_SLOW_BIT] ?
            SLOT_SLOW_CYC : SLOT_NORMAL_CYC;
        if (cfg6_r[`FAR_CFG6_REMOTE1_BIT]) begin
            slot_len = 28'(slot_len * `FAR_SLOW_FACTOR);
        end
        slot_tick = (slot_cnt_r >= 28'(slot_len - 28'h1));
        slot_cnt_nxt = slot_tick ? 28'h0 : 28'(slot_cnt_r + 28'h1);
    end

    // duty selection and smoothing
    far_pkg::far_duty_t duty_nxt [3];
    far_pkg::far_duty_t tgt [3];
    far_pkg::far_duty_t mins [3];
    logic [2:0] floor_sel;
    logic [2:0] sense_nxt;
    logic [2:0] sense_r;

    always_comb begin
        mins[0] = I_MIN_DUTY_1;
        mins[1] = I_MIN_DUTY_2;
        mins[2] = I_MIN_DUTY_3;
        tgt[0] = I_TARGET_DUTY_1;
        tgt[1] = I_TARGET_DUTY_2;
        tgt[2] = I_TARGET_DUTY_3;
        floor_sel = {ramp_rate_code_r[`FAR_DRIVE3_LOW_TEMP_FLOOR_SELECT_BIT], ramp_rate_code_r[`FAR_DRIVE2_LOW_TEMP_FLOOR_SELECT_BIT],
            ramp_rate_code_r[`FAR_DRIVE1_LOW_TEMP_FLOOR_SELECT_BIT]};
        for (int i = 0; i < 3; i++) begin
            duty_nxt[i] = duty_r[i];
            if (dctl_r[`FAR_DCTL_AUTO_LSB + i] && I_BELOW_LOW[i]) begin
                tgt[i] = floor_sel[i] ? mins[i] : 8'h00;
            end
            if (!dctl_r[`FAR_DCTL_REMOTE1_LSB + i]) begin
                duty_nxt[i] = tgt[i];
            end else if (!ramp_rate_code_r[`FAR_EN1_BIT]) begin
                duty_nxt[i] = tgt[i];
            end else if (slot_tick) begin
                duty_nxt[i] = ramp_toward(duty_r[i], tgt[i],
                    step_of(ramp_rate_code_r[`FAR_RAMP_RATE_CODE_MSB:`FAR_RAMP_RATE_CODE_LSB]));
            end
        end
        // speed senses 3 and 4 always follow drive 3
        sense_nxt = {1'b1, 1'b1, ramp_rate_code_r[`FAR_SYNC_BIT]};
    end

    always_ff @(posedge I_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            slot_cnt_r <= 28'h0;
            duty_r[0] <= 8'h00;
            duty_r[1] <= 8'h00;
            duty_r[2] <= 8'h00;
            sense_r <= 3'h0;
        end else begin
            slot_cnt_r <= slot_cnt_nxt;
            duty_r[0] <= duty_nxt[0];
            duty_r[1] <= duty_nxt[1];
            duty_r[2] <= duty_nxt[2];
            sense_r <= sense_nxt;
        end
    end

    // pwm waveform, 255 slots per period so 8'hff is fully on
    logic [7:0] pwm_cnt_r;
    logic [7:0] pwm_cnt_nxt;
    logic [2:0] pwm_r;
    logic [2:0] pwm_nxt;

    always_comb begin
        pwm_cnt_nxt = (pwm_cnt_r == 8'hfe) ? 8'h00 : 8'(pwm_cnt_r + 8'h01);
        for (int i = 0; i < 3; i++) begin
            pwm_nxt[i] = (pwm_cnt_r < duty_r[i]);
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pwm_cnt_r <= 8'h00;
            pwm_r <= 3'h0;
        end else begin
            pwm_cnt_r <= pwm_cnt_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign O_PREADY = pready_r;
    assign O_PRDATA = prdata_r;
    assign O_PSLVERR = pslverr_r;
    assign O_FAN_DRIVE_1 = pwm_r[0];
    assign O_FAN_DRIVE_2 = pwm_r[1];
    assign O_FAN_DRIVE_3 = pwm_r[2];
    assign O_DUTY_1 = duty_r[0];
    assign O_DUTY_2 = duty_r[1];
    assign O_DUTY_3 = duty_r[2];
    assign O_SPEED_SENSE_2_SYNC = sense_r[0];
    assign O_SPEED_SENSE_3_SYNC = sense_r[1];
    assign O_SPEED_SENSE_4_SYNC = sense_r[2];

endmodule // far_ctrl

// File: core/far_regs.svh
// register indices, field positions, reset values and ramp timing
`ifndef FAR_REGS_SVH
`define FAR_REGS_SVH
// printed offsets are indices; byte address is four times the index
`define FAR_IDX_CFG6 10'h010
`define FAR_IDX_ACOUSTIC1 10'h062
`define FAR_IDX_CFG1 10'h070
`define FAR_IDX_DRIVE_CTRL 10'h071
`define FAR_IDX_DUTY_STAT 10'h072
// acoustic register fields
`define FAR_RAMP_RATE_CODE_LSB 0
`define FAR_RAMP_RATE_CODE_MSB 2
`define FAR_EN1_BIT 3
`define FAR_SYNC_BIT 4
`define FAR_DRIVE1_LOW_TEMP_FLOOR_SELECT_BIT 5
`define FAR_DRIVE2_LOW_TEMP_FLOOR_SELECT_BIT 6
`define FAR_DRIVE3_LOW_TEMP_FLOOR_SELECT_BIT 7
// configuration six and one fields
`define FAR_CFG6_SLOW_BIT 7
`define FAR_CFG6_REMOTE1_BIT 0
`define FAR_CFG1_LOCK_BIT 1
// drive control fields
`define FAR_DCTL_AUTO_LSB 0
`define FAR_DCTL_REMOTE1_LSB 3
// reset values
`define FAR_ACOUSTIC1_RST 8'h00
`define FAR_CFG6_RST 8'h00
`define FAR_CFG1_RST 8'h00
`define FAR_DCTL_RST 8'h00
// duty steps per time slot for ramp codes 0 to 7
`define FAR_STEP_0 8'h01
`define FAR_STEP_1 8'h02
`define FAR_STEP_2 8'h03
`define FAR_STEP_3 8'h04
`define FAR_STEP_4 8'h08
`define FAR_STEP_5 8'h0c
`define FAR_STEP_6 8'h18
`define FAR_STEP_7 8'h30
// full-scale ramp times in ms at one step per slot, clock in kHz
`define FAR_RAMP_NORMAL_MS 64'd37500
`define FAR_RAMP_SLOW_MS 64'd52200
`define FAR_FULL_STEPS 64'd255
`define FAR_CLK_KHZ 64'd125000
`define FAR_SLOW_FACTOR 3'd4
`define FAR_SLOT_NORMAL_CYC \
    (`FAR_RAMP_NORMAL_MS * `FAR_CLK_KHZ / `FAR_FULL_STEPS)
`define FAR_SLOT_SLOW_CYC \
    (`FAR_RAMP_SLOW_MS * `FAR_CLK_KHZ / `FAR_FULL_STEPS)
`endif

// File: core/far_pkg.sv
// shared types of the fan acoustic ramp control block
package far_pkg;
    typedef logic [7:0] far_duty_t;
    typedef logic [27:0] far_slot_t;
    typedef enum logic {
        FAR_APB_IDLE,
        FAR_APB_ANSWER
    } far_apb_e;
endpackage

// File: test/far_fan_model.sv
// fan model: counts drive-pin high cycles over each 255-cycle window
`timescale 1ns/1ns
module far_fan_model (
    input wire logic i_clk,
    input wire logic i_pin,
    output logic [7:0] o_high
);
    logic [7:0] n_r = 8'h00;
    logic [7:0] h_r = 8'h00;
    // window equals the pwm period, so any phase yields the exact duty
    always_ff @(posedge i_clk) begin
        n_r <= (n_r == 8'hfe) ? 8'h00 : n_r + 8'h01;
        h_r <= (n_r == 8'hfe) ? 8'h00 : h_r + {7'h00, i_pin};
        if (n_r == 8'hfe) begin
            o_high <= h_r + {7'h00, i_pin};
        end
    end
endmodule // far_fan_model

// File: test/far_ctrl_chk.sv
// assertions on the fan acoustic ramp control ports
`timescale 1ns/1ns
module far_ctrl_chk (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [7:0] I_TARGET_DUTY_1,
    input wire logic [7:0] I_MIN_DUTY_1,
    input wire logic [2:0] I_BELOW_LOW,
    input wire logic O_FAN_DRIVE_1,
    input wire logic [7:0] O_DUTY_1,
    input wire logic O_SPEED_SENSE_2_SYNC,
    input wire logic O_SPEED_SENSE_3_SYNC,
    input wire logic O_SPEED_SENSE_4_SYNC
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    logic [7:0] ramp_rate_code_r, dctl_r, exp1, stp;
    logic lock_r, wr, wr_ramp_rate_code, ramp1;
    logic [2:0] up_r;
    logic [7:0] stp_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
        8'h08, 8'h0c, 8'h18, 8'h30};
    assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    assign wr_ramp_rate_code = wr && I_PADDR == 12'h188;
    assign ramp1 = ramp_rate_code_r[3] && dctl_r[3];
    assign stp = stp_tab[ramp_rate_code_r[2:0]];
    assign exp1 = (dctl_r[0] && I_BELOW_LOW[0]) ?
        (ramp_rate_code_r[5] ? I_MIN_DUTY_1 : 8'h00) : I_TARGET_DUTY_1;
    // shadow copies; the lock only ever sets until the next reset
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ramp_rate_code_r <= 8'h00;
            dctl_r <= 8'h00;
            lock_r <= 1'b0;
            up_r <= 3'b000;
        end else begin
            up_r <= {up_r[1:0], 1'b1};
            if (wr && I_PADDR == 12'h1c0 && I_PWDATA[1]) lock_r <= 1'b1;
            if (wr && I_PADDR == 12'h1c4) dctl_r <= I_PWDATA[7:0];
            if (wr_ramp_rate_code && !lock_r) ramp_rate_code_r <= I_PWDATA[7:0];
        end
    end
    property p_direct;
        up_r[2] && !ramp1 |=> O_DUTY_1 == $past(exp1);
    endproperty
    a_ready_wait: assert property ($rose(I_PENABLE) && I_PSEL |=>
        O_PREADY)
        else $error("no answer one cycle into access");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held past one cycle");
    a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
    a_sense_fixed: assert property ($past(O_SPEED_SENSE_3_SYNC) |->
        O_SPEED_SENSE_3_SYNC && O_SPEED_SENSE_4_SYNC)
        else $error("senses 3 and 4 left drive 3");
    a_sense2_sync: assert property ($past(wr_ramp_rate_code, 2) |->
        O_SPEED_SENSE_2_SYNC == ramp_rate_code_r[4])
        else $error("sense 2 sync differs from register");
    a_duty_floor: assert property (p_direct)
        else $error("drive 1 duty not the direct target");
    a_ramp_step: assert property (up_r[2] && ramp1 |=>
        (O_DUTY_1 - $past(O_DUTY_1) <= $past(stp)) ||
        ($past(O_DUTY_1) - O_DUTY_1 <= $past(stp)))
        else $error("ramped duty jumped too far");
    a_pin_off: assert property ($past(O_DUTY_1) == 8'h00 |->
        !O_FAN_DRIVE_1)
        else $error("drive pin high at zero duty");
    c_locked_write: cover property (lock_r && wr_ramp_rate_code);
    c_ramp_move: cover property (ramp1 && O_DUTY_1 != $past(O_DUTY_1));
    c_floor_min: cover property (dctl_r[0] && I_BELOW_LOW[0] && ramp_rate_code_r[5]);
endmodule // far_ctrl_chk
bind far_ctrl far_ctrl_chk u_chk (.I_CLK, .I_RSTN, .I_PSEL, .I_PENABLE,
    .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR, .I_TARGET_DUTY_1,
    .I_MIN_DUTY_1, .I_BELOW_LOW, .O_FAN_DRIVE_1, .O_DUTY_1,
    .O_SPEED_SENSE_2_SYNC, .O_SPEED_SENSE_3_SYNC, .O_SPEED_SENSE_4_SYNC);

// File: test/tb.sv
// testbench: register access, floors, ramp timing and lock
`timescale 1ns/1ns
`include "far_regs.svh"
module tb;
    logic I_CLK, I_RSTN = 1'b0, I_PSEL = 1'b0, I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0;
    logic [11:0] I_PADDR = 12'h000;
    logic [31:0] I_PWDATA = 32'h0, O_PRDATA;
    logic O_PREADY, O_PSLVERR, O_FAN_DRIVE_1, O_FAN_DRIVE_2, O_FAN_DRIVE_3;
    logic [7:0] I_TARGET_DUTY_1 = 8'hc0, I_TARGET_DUTY_2 = 8'hc1;
    logic [7:0] I_TARGET_DUTY_3 = 8'hc2, I_MIN_DUTY_1 = 8'h40;
    logic [7:0] I_MIN_DUTY_2 = 8'h50, I_MIN_DUTY_3 = 8'h60;
    logic [7:0] O_DUTY_1, O_DUTY_2, O_DUTY_3, meas, meas2, meas3;
    logic [2:0] I_BELOW_LOW = 3'b111;
    logic O_SPEED_SENSE_2_SYNC, O_SPEED_SENSE_3_SYNC, O_SPEED_SENSE_4_SYNC;
    int err_total = 0;
    int n_checks = 0;
    int n, k;
    localparam logic [11:0] A_CFG6 = {`FAR_IDX_CFG6, 2'b00};
    localparam logic [11:0] A_RAMP_RATE_CODE = {`FAR_IDX_ACOUSTIC1, 2'b00};
    localparam logic [11:0] A_CFG1 = {`FAR_IDX_CFG1, 2'b00};
    localparam logic [11:0] A_DCTL = {`FAR_IDX_DRIVE_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {`FAR_IDX_DUTY_STAT, 2'b00};
    localparam logic [7:0] C6 [3] = '{8'h00, 8'h80, 8'h81};
    localparam int PER [3] = '{4, 6, 24};
    localparam int STEP [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    far_ctrl #(.SLOT_NORMAL_CYC(28'd4), .SLOT_SLOW_CYC(28'd6)) uut (.I_CLK,
        .I_RSTN, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
        .O_PREADY, .O_PRDATA, .O_PSLVERR, .I_TARGET_DUTY_1, .I_TARGET_DUTY_2,
        .I_TARGET_DUTY_3, .I_MIN_DUTY_1, .I_MIN_DUTY_2, .I_MIN_DUTY_3,
        .I_BELOW_LOW, .O_FAN_DRIVE_1, .O_FAN_DRIVE_2, .O_FAN_DRIVE_3,
        .O_DUTY_1, .O_DUTY_2, .O_DUTY_3, .O_SPEED_SENSE_2_SYNC,
        .O_SPEED_SENSE_3_SYNC, .O_SPEED_SENSE_4_SYNC);
    far_fan_model u_fan (.i_clk(I_CLK), .i_pin(O_FAN_DRIVE_1), .o_high(meas));
    far_fan_model u_fan2 (.i_clk(I_CLK), .i_pin(O_FAN_DRIVE_2),
        .o_high(meas2));
    far_fan_model u_fan3 (.i_clk(I_CLK), .i_pin(O_FAN_DRIVE_3),
        .o_high(meas3));
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ready, data and error are taken at the edge that samples ready high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int t;
        @(posedge I_CLK);
        I_PSEL <= 1'b1;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        t = 0;
        do begin
            @(posedge I_CLK);
            t++;
        end while (O_PREADY !== 1'b1 && t < 20);
        r = O_PRDATA;
        e = O_PSLVERR;
        if (O_PREADY !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, ex});
    endtask
    initial begin
        I_CLK = 1'b0;
        forever #4 I_CLK = ~I_CLK;
    end
    initial begin
        repeat (3) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        repeat (3) @(posedge I_CLK);
        rd(A_RAMP_RATE_CODE, 32'h0, 1'b0);
        chk({29'h0, O_SPEED_SENSE_4_SYNC, O_SPEED_SENSE_3_SYNC,
            O_SPEED_SENSE_2_SYNC}, 32'h6);
        wr(A_RAMP_RATE_CODE, 8'h10);
        rd(A_RAMP_RATE_CODE, 32'h10, 1'b0);
        chk({29'h0, O_SPEED_SENSE_4_SYNC, O_SPEED_SENSE_3_SYNC,
            O_SPEED_SENSE_2_SYNC}, 32'h7);
        $display("test reset and sync done");
        wr(A_DCTL, 8'h07);
        for (int m = 0; m < 8; m++) begin
            wr(A_RAMP_RATE_CODE, 8'(m << 5));
            rd(A_STAT, {8'h0, m[2] ? 8'h60 : 8'h00,
                m[1] ? 8'h50 : 8'h00, m[0] ? 8'h40 : 8'h00}, 1'b0);
        end
        repeat (520) @(posedge I_CLK);
        chk({8'h0, meas3, meas2, meas}, 32'h605040);
        chk({8'h0, O_DUTY_3, O_DUTY_2, O_DUTY_1}, 32'h605040);
        I_BELOW_LOW <= 3'b000;
        rd(A_STAT, 32'hc2c1c0, 1'b0);
        $display("test floor done");
        wr(A_DCTL, 8'h08);
        for (int c = 0; c < 3; c++) begin
            wr(A_CFG6, C6[c]);
            for (int s = 0; s < 8; s++) begin
                wr(A_RAMP_RATE_CODE, 8'h00);
                I_TARGET_DUTY_1 <= 8'h00;
                repeat (2) @(posedge I_CLK);
                chk({24'h0, O_DUTY_1}, 32'h0);
                wr(A_RAMP_RATE_CODE, 8'h08 | 8'(s));
                I_TARGET_DUTY_1 <= 8'h60;
                n = 0;
                do begin
                    @(negedge I_CLK);
                    n++;
                end while (O_DUTY_1 !== 8'h60 && n < 4000);
                k = (96 + STEP[s] - 1) / STEP[s];
                chk({31'h0, n > (k - 1) * PER[c] &&
                    n <= k * PER[c] + 2}, 32'h1);
            end
        end
        $display("test ramp timing done");
        wr(A_RAMP_RATE_CODE, 8'h55);
        wr(A_CFG1, 8'h02);
        wr(A_RAMP_RATE_CODE, 8'haa);
        rd(A_RAMP_RATE_CODE, 32'h55, 1'b0);
        rd(A_CFG1, 32'h2, 1'b0);
        rd(12'h004, 32'h0, 1'b1);
        rd(A_RAMP_RATE_CODE | 12'h002, 32'h0, 1'b1);
        $display("test lock and unmapped done");
        // a second reset must clear the lock as well as the register
        I_RSTN <= 1'b0;
        repeat (3) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        repeat (3) @(posedge I_CLK);
        rd(A_RAMP_RATE_CODE, 32'h0, 1'b0);
        wr(A_RAMP_RATE_CODE, 8'haa);
        rd(A_RAMP_RATE_CODE, 32'haa, 1'b0);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule // tb
